/* pptc_top.sv */
// Physical-layer test and link-state control register bank.
// Assumes configuration accesses and side-port/EEPROM loads are on clk_in.
// Contract
// - Speed/de-emphasis word exists only on upstream port
// - Speed field: 0 gen1, 1 gen2
// - De-emphasis field: 0 -6dB, 1 -3.5dB
// - Writing 1 forces link into compliance
// - Hold-off bit forces LTSSM into Detect.Quiet
// - Stay-idle bit keeps LTSSM in Detect.Quiet
// - Bits 0,1,5,6,7 map ports 0,2,10,12,14
// - Clear hold-off bit means normal LTSSM
`timescale 1ns/100ps
`default_nettype none
module pptc_top
    import pptc_pkg::*;
#(
    parameter bit UPSTREAM = 1'b1
) (
    // Clock and reset
    input  wire logic        clk_in,
    input  wire logic        rst_n_in,
    // Configuration access
    input  wire logic        cfg_wr_in,
    input  wire logic        cfg_rd_in,
    input  wire logic [11:0] cfg_addr_in,
    input  wire logic [31:0] cfg_wdata_in,
    output logic      [31:0] cfg_rdata_out,
    output logic             cfg_rvalid_out,
    // Side-port or EEPROM load, same format as a write
    input  wire logic        load_in,
    input  wire logic [11:0] load_addr_in,
    input  wire logic [31:0] load_data_in,
    // Link test controls; speed and de-emphasis upstream only
    output logic             link_gen2_out,
    output logic             tx_deemph_select_out,
    output logic             compliance_force_out,
    // Per-port controls, index is port number 0..15, then the even pattern rate byte
    output logic      [15:0] port_loopback_request_out,
    output logic      [15:0] port_scrambler_bypass_out,
    output logic      [15:0] port_compliance_rx_request_out,
    output logic      [15:0] ltssm_hold_off_out,
    output logic      [15:0] ltssm_stay_idle_out,
    output logic      [7:0]  even_pattern_rate_out
);
    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    // Each field must fit the 32-bit word and leave its neighbour alone;
    // a package edit that broke this would alias two controls silently
    if (PPTC_SPEED_LSB + 16 > PPTC_DEEMPH_LSB) begin : g_bad_speed
        $error("speed field overlaps the de-emphasis field");
    end
    if (PPTC_DEEMPH_LSB + 16 > 32) begin : g_bad_deemph
        $error("de-emphasis field does not fit the word");
    end
    if (PPTC_STAYIDLE_LSB + 8 > PPTC_PATRATE_LSB) begin : g_bad_idle
        $error("stay-idle byte overlaps the pattern rate field");
    end
    if (PPTC_PATRATE_LSB + 8 > 32) begin : g_bad_rate
        $error("pattern rate field does not fit the word");
    end
    // The fan out packs three command bits into each four-bit group
    if (PPTC_CMD_COMPRX > 3) begin : g_bad_cmd
        $error("command bits leave their four-bit group");
    end

    // ------------------------------------------------------------
    // Write selection
    // ------------------------------------------------------------
    // Configuration write wins over a load in the same cycle
    logic        wr_any;
    logic [11:0] wr_addr;
    logic [31:0] wr_data;
    logic [31:0] speed_q;
    logic [31:0] compl_q;
    logic [31:0] evencmd_q;
    logic [31:0] oddcmd_q;
    logic [31:0] hold_q;

    assign wr_any  = cfg_wr_in | load_in;
    assign wr_addr = cfg_wr_in ? cfg_addr_in : load_addr_in;
    assign wr_data = cfg_wr_in ? cfg_wdata_in : load_data_in;

    // Word match; byte lane bits are ignored since access is whole words
    function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
        hit = (a[11:2] == off[11:2]);
    endfunction

    // ------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------
    // Downstream instances keep no storage for the speed word
    pptc_reg #(.MASK(UPSTREAM ? PPTC_MASK_SPEED : 32'h0000_0000)) u_speed (
        .clk_in     (clk_in),
        .rst_n_in   (rst_n_in),
        .wr_en_in   (wr_any && hit(wr_addr, PPTC_OFF_SPEED_DEEMPH)),
        .wr_data_in (wr_data),
        .value_out  (speed_q)
    );
    pptc_reg #(.MASK(PPTC_MASK_COMPL)) u_compl (
        .clk_in     (clk_in),
        .rst_n_in   (rst_n_in),
        .wr_en_in   (wr_any && hit(wr_addr, PPTC_OFF_COMPLIANCE)),
        .wr_data_in (wr_data),
        .value_out  (compl_q)
    );
    pptc_reg #(.MASK(PPTC_MASK_EVENCMD)) u_evencmd (
        .clk_in     (clk_in),
        .rst_n_in   (rst_n_in),
        .wr_en_in   (wr_any && hit(wr_addr, PPTC_OFF_EVEN_CMD)),
        .wr_data_in (wr_data),
        .value_out  (evencmd_q)
    );
    pptc_reg #(.MASK(PPTC_MASK_ODDCMD)) u_oddcmd (
        .clk_in     (clk_in),
        .rst_n_in   (rst_n_in),
        .wr_en_in   (wr_any && hit(wr_addr, PPTC_OFF_ODD_CMD)),
        .wr_data_in (wr_data),
        .value_out  (oddcmd_q)
    );
    pptc_reg #(.MASK(PPTC_MASK_HOLD)) u_hold (
        .clk_in     (clk_in),
        .rst_n_in   (rst_n_in),
        .wr_en_in   (wr_any && hit(wr_addr, PPTC_OFF_EVEN_HOLD)),
        .wr_data_in (wr_data),
        .value_out  (hold_q)
    );

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    // One cycle read latency; unmapped offsets read zero
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            cfg_rdata_out  <= 32'h0000_0000;
            cfg_rvalid_out <= 1'b0;
        end else begin
            cfg_rvalid_out <= cfg_rd_in;
            if (!cfg_rd_in) begin
                cfg_rdata_out <= 32'h0000_0000;
            end else if (hit(cfg_addr_in, PPTC_OFF_SPEED_DEEMPH)) begin
                cfg_rdata_out <= speed_q;
            end else if (hit(cfg_addr_in, PPTC_OFF_COMPLIANCE)) begin
                cfg_rdata_out <= compl_q;
            end else if (hit(cfg_addr_in, PPTC_OFF_EVEN_CMD)) begin
                cfg_rdata_out <= evencmd_q;
            end else if (hit(cfg_addr_in, PPTC_OFF_ODD_CMD)) begin
                cfg_rdata_out <= oddcmd_q;
            end else if (hit(cfg_addr_in, PPTC_OFF_EVEN_HOLD)) begin
                cfg_rdata_out <= hold_q;
            end else begin
                cfg_rdata_out <= 32'h0000_0000;
            end
        end
    end

    // ------------------------------------------------------------
    // Link test decode
    // ------------------------------------------------------------
    // Only the documented codes act; other codes behave as value 0
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            link_gen2_out        <= 1'b0;
            tx_deemph_select_out <= 1'b0;
            compliance_force_out <= 1'b0;
        end else begin
            link_gen2_out        <= UPSTREAM &&
                (speed_q[PPTC_SPEED_LSB +: 16] == PPTC_SPEED_GEN2);
            tx_deemph_select_out <= UPSTREAM &&
                (speed_q[PPTC_DEEMPH_LSB +: 16] == PPTC_DEEMPH_3P5DB);
            compliance_force_out <= (compl_q[15:0] == PPTC_COMPL_ENTER);
        end
    end

    // ------------------------------------------------------------
    // Per-port fan out
    // ------------------------------------------------------------
    // Port p sits in nibble p/2 of the even or odd command word
    logic [15:0] lb_d;
    logic [15:0] sb_d;
    logic [15:0] cr_d;
    logic [15:0] ho_d;
    logic [15:0] si_d;

    always_comb begin
        for (int p = 0; p < 16; p++) begin
            lb_d[p] = (p % 2 == 0) ? evencmd_q[(p/2)*4 + PPTC_CMD_LOOPBACK]
                                   : oddcmd_q[(p/2)*4 + PPTC_CMD_LOOPBACK];
            sb_d[p] = (p % 2 == 0) ? evencmd_q[(p/2)*4 + PPTC_CMD_SCRAMBLE]
                                   : oddcmd_q[(p/2)*4 + PPTC_CMD_SCRAMBLE];
            cr_d[p] = (p % 2 == 0) ? evencmd_q[(p/2)*4 + PPTC_CMD_COMPRX]
                                   : oddcmd_q[(p/2)*4 + PPTC_CMD_COMPRX];
            ho_d[p] = 1'b0;
            si_d[p] = 1'b0;
        end
        // Bit b of each byte serves even port 2*b
        for (int b = 0; b < 8; b++) begin
            ho_d[2*b] = hold_q[PPTC_HOLDOFF_LSB + b];
            si_d[2*b] = hold_q[PPTC_STAYIDLE_LSB + b];
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            port_loopback_request_out      <= 16'h0000;
            port_scrambler_bypass_out      <= 16'h0000;
            port_compliance_rx_request_out <= 16'h0000;
            ltssm_hold_off_out             <= 16'h0000;
            ltssm_stay_idle_out            <= 16'h0000;
            even_pattern_rate_out          <= 8'h00;
        end else begin
            port_loopback_request_out      <= lb_d;
            port_scrambler_bypass_out      <= sb_d;
            port_compliance_rx_request_out <= cr_d;
            ltssm_hold_off_out             <= ho_d;
            ltssm_stay_idle_out            <= si_d;
            even_pattern_rate_out          <= hold_q[PPTC_PATRATE_LSB +: 8];
        end
    end
endmodule
`default_nettype wire

/* pptc_pkg.sv */
// Package for the physical-layer port test control register bank.
// Assumes a 12-bit configuration byte address and 32-bit data words.
package pptc_pkg;
    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [11:0] PPTC_OFF_SPEED_DEEMPH = 12'h208;
    localparam logic [11:0] PPTC_OFF_COMPLIANCE   = 12'h20c;
    localparam logic [11:0] PPTC_OFF_EVEN_CMD     = 12'h220;
    localparam logic [11:0] PPTC_OFF_ODD_CMD      = 12'h224;
    localparam logic [11:0] PPTC_OFF_EVEN_HOLD    = 12'h230;

    // ------------------------------------------------------------
    // Field positions and masks
    // ------------------------------------------------------------
    localparam int PPTC_SPEED_LSB    = 0;
    localparam int PPTC_DEEMPH_LSB   = 16;
    localparam int PPTC_HOLDOFF_LSB  = 0;
    localparam int PPTC_STAYIDLE_LSB = 8;
    localparam int PPTC_PATRATE_LSB  = 16;
    localparam int PPTC_CMD_LOOPBACK = 0;
    localparam int PPTC_CMD_SCRAMBLE = 1;
    localparam int PPTC_CMD_COMPRX   = 2;
    // Writable masks: reserved bits read zero
    localparam logic [31:0] PPTC_MASK_SPEED   = 32'hffff_ffff;
    localparam logic [31:0] PPTC_MASK_COMPL   = 32'h0000_ffff;
    localparam logic [31:0] PPTC_MASK_EVENCMD = 32'h7770_0077;
    localparam logic [31:0] PPTC_MASK_ODDCMD  = 32'h7770_0070;
    localparam logic [31:0] PPTC_MASK_HOLD    = 32'h00ff_e3e3;

    // ------------------------------------------------------------
    // Encodings and reset values
    // ------------------------------------------------------------
    localparam logic [15:0] PPTC_SPEED_GEN1   = 16'h0000;
    localparam logic [15:0] PPTC_SPEED_GEN2   = 16'h0001;
    localparam logic [15:0] PPTC_DEEMPH_6DB   = 16'h0000;
    localparam logic [15:0] PPTC_DEEMPH_3P5DB = 16'h0001;
    localparam logic [15:0] PPTC_COMPL_ENTER  = 16'h0001;
    localparam logic [31:0] PPTC_RESET_VALUE  = 32'h0000_0000;
endpackage

/* pptc_reg.sv */
// Single masked read-write register word with reset to zero.
// Assumes write strobe and data come from the same clock domain.
`timescale 1ns/100ps
`default_nettype none
module pptc_reg
    import pptc_pkg::*;
#(
    parameter logic [31:0] MASK = 32'hffff_ffff
) (
    // Clock and reset
    input  wire logic        clk_in,
    input  wire logic        rst_n_in,
    // Write side
    input  wire logic        wr_en_in,
    input  wire logic [31:0] wr_data_in,
    // Stored value
    output logic      [31:0] value_out
);
    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    // Reserved bits are never stored, so they always read zero
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            value_out <= PPTC_RESET_VALUE;
        end else if (wr_en_in) begin
            value_out <= wr_data_in & MASK;
        end
    end
endmodule
`default_nettype wire

/* pptc_monitor.sv */
// Assertions on the port test control bank, watching top-level ports only.
// Assumes it is bound into pptc_top with UPSTREAM handed on.
`timescale 1ns/100ps
`default_nettype none
module pptc_monitor
    import pptc_pkg::*;
#(
    parameter bit UPSTREAM = 1'b1
) (
    // Clock, reset and requests
    input wire logic        clk_in,
    input wire logic        rst_n_in,
    input wire logic        cfg_wr_in,
    input wire logic        cfg_rd_in,
    input wire logic        load_in,
    input wire logic [11:0] cfg_addr_in,
    input wire logic [11:0] load_addr_in,
    input wire logic [31:0] cfg_wdata_in,
    input wire logic [31:0] load_data_in,
    // Answers and controls
    input wire logic [31:0] cfg_rdata_out,
    input wire logic        cfg_rvalid_out,
    input wire logic        link_gen2_out,
    input wire logic        tx_deemph_select_out,
    input wire logic        compliance_force_out,
    input wire logic [15:0] port_loopback_request_out,
    input wire logic [15:0] ltssm_hold_off_out,
    input wire logic [15:0] ltssm_stay_idle_out,
    input wire logic [7:0]  even_pattern_rate_out
);
    // ----------------------------------------
    // Write decode
    // ----------------------------------------
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    wire logic w_spd = cfg_wr_in && cfg_addr_in[11:2] == 10'h082;
    wire logic w_cmp = cfg_wr_in && cfg_addr_in[11:2] == 10'h083;
    wire logic w_cmd = cfg_wr_in && cfg_addr_in[11:2] == 10'h088;
    wire logic w_hld = cfg_wr_in && cfg_addr_in[11:2] == 10'h08c;
    wire logic l_hld = load_in && !cfg_wr_in && load_addr_in[11:2] == 10'h08c;
    wire logic quiet = !cfg_wr_in && !load_in;
    // Byte bits 0,1,5,6,7 land on ports 0,2,10,12,14; odd ports never
    function automatic logic [15:0] spread(input logic [7:0] b);
        return {1'b0, b[7], 1'b0, b[6], 1'b0, b[5], 7'h00, b[1], 1'b0, b[0]};
    endfunction
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    read_answer_a: assert property (cfg_rd_in |=> cfg_rvalid_out)
        else $error("read answer missing");
    speed_sel_a: assert property (w_spd |=> ##1
        link_gen2_out == (UPSTREAM && $past(cfg_wdata_in[15:0], 2) == PPTC_SPEED_GEN2))
        else $error("speed select wrong");
    deemph_sel_a: assert property (w_spd |=> ##1
        tx_deemph_select_out == (UPSTREAM && $past(cfg_wdata_in[31:16], 2) == PPTC_DEEMPH_3P5DB))
        else $error("de-emphasis select wrong");
    compliance_a: assert property (w_cmp |=> ##1
        compliance_force_out == ($past(cfg_wdata_in[15:0], 2) == PPTC_COMPL_ENTER))
        else $error("compliance entry wrong");
    hold_map_a: assert property (w_hld |=> ##1
        ltssm_hold_off_out == spread($past(cfg_wdata_in[7:0], 2)))
        else $error("hold-off map wrong");
    idle_map_a: assert property (w_hld |=> ##1
        ltssm_stay_idle_out == spread($past(cfg_wdata_in[15:8], 2)))
        else $error("stay-idle map wrong");
    odd_clear_a: assert property (((ltssm_hold_off_out | ltssm_stay_idle_out) & 16'haaaa) == 16'h0)
        else $error("odd port hold bit set");
    hold_steady_a: assert property (quiet [*2] |=>
        $stable(ltssm_hold_off_out) && $stable(ltssm_stay_idle_out))
        else $error("hold bits moved without a write");
    loop_cmd_a: assert property (w_cmd |=> ##1
        port_loopback_request_out[14] == $past(cfg_wdata_in[28], 2))
        else $error("port 14 loopback wrong");
    load_rate_a: assert property (l_hld |=> ##1
        even_pattern_rate_out == $past(load_data_in[23:16], 2))
        else $error("loaded pattern rate wrong");
    cover property (cfg_rd_in ##1 cfg_rvalid_out);
    cover property (w_hld ##2 ltssm_hold_off_out != 16'h0);
    cover property (l_hld);
endmodule
`default_nettype wire

/* phy_port_test_control_test.sv */
// Self-checking bench for the port test control bank.
// Assumes pptc_pkg, pptc_top and pptc_monitor are compiled before it.
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin fail_count++; \
    $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module phy_port_test_control_test
    import pptc_pkg::*;
;
    logic        clk_in = 1'b0, rst_n_in = 1'b0, cfg_wr_in = 1'b0, cfg_rd_in = 1'b0, load_in = 1'b0;
    logic [11:0] cfg_addr_in = 12'h0, load_addr_in = 12'h0;
    logic [31:0] cfg_wdata_in = 32'h0, load_data_in = 32'h0, cfg_rdata_out, r, d;
    logic        cfg_rvalid_out, link_gen2_out, tx_deemph_select_out, compliance_force_out;
    logic [15:0] port_loopback_request_out, port_scrambler_bypass_out, port_compliance_rx_request_out;
    logic [15:0] ltssm_hold_off_out, ltssm_stay_idle_out;
    logic [7:0]  even_pattern_rate_out;
    logic [31:0] dn_rdata;
    logic        dn_gen2, dn_deemph;
    logic [31:0] exp_q[$];
    logic [11:0] adr[5] = '{PPTC_OFF_SPEED_DEEMPH, PPTC_OFF_COMPLIANCE, PPTC_OFF_EVEN_CMD, PPTC_OFF_ODD_CMD, 12'h230};
    logic [31:0] msk[5] = '{PPTC_MASK_SPEED, PPTC_MASK_COMPL, PPTC_MASK_EVENCMD, PPTC_MASK_ODDCMD, PPTC_MASK_HOLD};
    int          fail_count = 0, checks_done = 0, seed;
    pptc_top #(.UPSTREAM(1'b1)) u_dut (
        .clk_in (clk_in), .rst_n_in (rst_n_in), .cfg_wr_in (cfg_wr_in), .cfg_rd_in (cfg_rd_in),
        .cfg_addr_in (cfg_addr_in), .cfg_wdata_in (cfg_wdata_in), .cfg_rdata_out (cfg_rdata_out),
        .cfg_rvalid_out (cfg_rvalid_out), .load_in (load_in), .load_addr_in (load_addr_in),
        .load_data_in (load_data_in), .link_gen2_out (link_gen2_out),
        .tx_deemph_select_out (tx_deemph_select_out), .compliance_force_out (compliance_force_out),
        .port_loopback_request_out (port_loopback_request_out),
        .port_scrambler_bypass_out (port_scrambler_bypass_out),
        .port_compliance_rx_request_out (port_compliance_rx_request_out),
        .ltssm_hold_off_out (ltssm_hold_off_out), .ltssm_stay_idle_out (ltssm_stay_idle_out),
        .even_pattern_rate_out (even_pattern_rate_out)
    );
    // Downstream copy shares the inputs; it must keep no speed word at all
    pptc_top #(.UPSTREAM(1'b0)) u_dut_down (
        .clk_in (clk_in), .rst_n_in (rst_n_in), .cfg_wr_in (cfg_wr_in), .cfg_rd_in (cfg_rd_in),
        .cfg_addr_in (cfg_addr_in), .cfg_wdata_in (cfg_wdata_in), .cfg_rdata_out (dn_rdata),
        .cfg_rvalid_out (), .load_in (load_in), .load_addr_in (load_addr_in),
        .load_data_in (load_data_in), .link_gen2_out (dn_gen2),
        .tx_deemph_select_out (dn_deemph), .compliance_force_out (),
        .port_loopback_request_out (), .port_scrambler_bypass_out (),
        .port_compliance_rx_request_out (), .ltssm_hold_off_out (), .ltssm_stay_idle_out (),
        .even_pattern_rate_out ()
    );
    // 100 MHz clock
    always #5 clk_in = ~clk_in;
    // One access per cycle, launched at the falling edge; reads note their answer
    task automatic acc(input logic w, rd, input logic [11:0] a, input logic [31:0] wd, e);
        cfg_wr_in = w;
        cfg_rd_in = rd;
        cfg_addr_in = a;
        cfg_wdata_in = wd;
        if (rd) exp_q.push_back(e);
        @(negedge clk_in);
    endtask
    // Lets derived outputs settle, one edge behind the register
    task automatic idle2();
        acc(0, 0, 12'h0, 32'h0, 32'h0);
        acc(0, 0, 12'h0, 32'h0, 32'h0);
    endtask
    // Expected even-port mask for byte bit b; unlisted bits map to nothing
    function automatic logic [15:0] ev(input int b);
        return (b inside {0, 1, 5, 6, 7}) ? 16'h1 << (2 * b) : 16'h0;
    endfunction
    task automatic finish_test();
        $display("checks %0d failures %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // Read answers are compared mid-cycle against the oldest note
    always @(negedge clk_in) begin
        if (cfg_rvalid_out === 1'b1) begin
            r = exp_q.size() ? exp_q.pop_front() : 32'hx;
            `CHK("read data", r, cfg_rdata_out)
        end
    end
    // Watchdog far beyond the 140 or so cycles the run needs
    initial begin
        #100000;
        fail_count++;
        finish_test();
    end
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        seed = $urandom(32'ha6cc);
        repeat (20) @(negedge clk_in);
        rst_n_in = 1'b1;
        foreach (adr[i]) acc(0, 1, adr[i], 32'h0, 32'h0);
        acc(1, 0, 12'h210, 32'hffff_ffff, 32'h0);
        acc(0, 1, 12'h210, 32'h0, 32'h0);
        // All-ones then random words keep only their writable bits
        for (int k = 0; k < 6; k++) begin
            foreach (adr[i]) begin
                d = k ? $urandom : 32'hffff_ffff;
                acc(1, 0, adr[i], d, 32'h0);
                acc(0, 1, adr[i], 32'h0, d & msk[i]);
            end
        end
        // Codes 0 and 1 select, any other code acts as 0
        for (int c = 0; c < 3; c++) begin
            acc(1, 0, PPTC_OFF_SPEED_DEEMPH, {16'(c), 16'(c)}, 32'h0);
            acc(1, 0, PPTC_OFF_COMPLIANCE, 32'(c), 32'h0);
            acc(0, 1, PPTC_OFF_SPEED_DEEMPH, 32'h0, {16'(c), 16'(c)});
            `CHK("down word", 32'h0, dn_rdata)
            idle2();
            `CHK("down gen2", 1'b0, dn_gen2)
            `CHK("down deemph", 1'b0, dn_deemph)
            `CHK("gen2", c == 1, link_gen2_out)
            `CHK("deemph", c == 1, tx_deemph_select_out)
            `CHK("compliance", c == 1, compliance_force_out)
        end
        // Walk one hold bit up and one stay bit down the bytes
        for (int b = 0; b < 8; b++) begin
            acc(1, 0, 12'h230, (32'h1 << b) | (32'h100 << (7 - b)), 32'h0);
            idle2();
            `CHK("hold off", ev(b), ltssm_hold_off_out)
            `CHK("stay idle", ev(7 - b), ltssm_stay_idle_out)
        end
        acc(1, 0, PPTC_OFF_EVEN_CMD, 32'hffff_ffff, 32'h0);
        acc(1, 0, PPTC_OFF_ODD_CMD, 32'hffff_ffff, 32'h0);
        idle2();
        `CHK("loopback", 16'hfc0d, port_loopback_request_out)
        `CHK("scramble", 16'hfc0d, port_scrambler_bypass_out)
        `CHK("comp rx", 16'hfc0d, port_compliance_rx_request_out)
        // Side-port load colliding with a write loses, then lands alone
        load_addr_in = 12'h230;
        load_data_in = 32'h00aa_0000;
        load_in = 1'b1;
        acc(1, 0, 12'h230, 32'h0055_0000, 32'h0);
        load_in = 1'b0;
        acc(0, 1, 12'h230, 32'h0, 32'h0055_0000);
        load_in = 1'b1;
        acc(0, 0, 12'h0, 32'h0, 32'h0);
        load_in = 1'b0;
        idle2();
        `CHK("pattern rate", 8'haa, even_pattern_rate_out)
        `CHK("hold cleared", 16'h0, ltssm_hold_off_out)
        // Second reset clears everything again
        rst_n_in = 1'b0;
        idle2();
        rst_n_in = 1'b1;
        `CHK("loop after reset", 16'h0, port_loopback_request_out)
        acc(0, 1, PPTC_OFF_ODD_CMD, 32'h0, 32'h0);
        idle2();
        `CHK("notes left", 0, exp_q.size())
        finish_test();
    end
endmodule
bind pptc_top pptc_monitor #(.UPSTREAM(UPSTREAM)) u_mon (
    .clk_in (clk_in), .rst_n_in (rst_n_in), .cfg_wr_in (cfg_wr_in), .cfg_rd_in (cfg_rd_in),
    .load_in (load_in), .cfg_addr_in (cfg_addr_in), .load_addr_in (load_addr_in),
    .cfg_wdata_in (cfg_wdata_in), .load_data_in (load_data_in), .cfg_rdata_out (cfg_rdata_out),
    .cfg_rvalid_out (cfg_rvalid_out), .link_gen2_out (link_gen2_out),
    .tx_deemph_select_out (tx_deemph_select_out), .compliance_force_out (compliance_force_out),
    .port_loopback_request_out (port_loopback_request_out), .ltssm_hold_off_out (ltssm_hold_off_out),
    .ltssm_stay_idle_out (ltssm_stay_idle_out), .even_pattern_rate_out (even_pattern_rate_out)
);
`default_nettype wire
